/* File: lvpmc_defs.vh */
// register offsets, field positions, reset values and the interrupt block layout
// assumes a 32-bit avalon-mm slave with word addressing on byte addresses
`ifndef LVPMC_DEFS_VH
`define LVPMC_DEFS_VH

`define LVPMC_OFS_ONE      4'h0
`define LVPMC_OFS_TWO      4'h4
`define LVPMC_OFS_IRQ_STAT 4'h8
`define LVPMC_OFS_IRQ_MASK 4'hC

// first register
`define LVPMC_WARN_FLAG_BIT  7
`define LVPMC_WARN_ACK_BIT   6
`define LVPMC_WARN_IE_BIT    5
`define LVPMC_DET_RST_BIT    4
`define LVPMC_DET_STOP_BIT   3
`define LVPMC_DET_EN_BIT     2
`define LVPMC_BG_EN_BIT      0

// second register
`define LVPMC_DET_SEL_BIT    5
`define LVPMC_WARN_SEL_BIT   4
`define LVPMC_PPD_FLAG_BIT   3
`define LVPMC_PPD_CLR_BIT    2
`define LVPMC_DEEP_STOP_BIT  0

// interrupt status and mask bits
`define LVPMC_EV_WARN_BIT    0
`define LVPMC_EV_PPD_BIT     1
`define LVPMC_EV_DET_BIT     2

// control defaults after the ordinary reset; the trip selects clear only on power-on
`define LVPMC_WARN_IE_RST    1'h0
`define LVPMC_DET_RST_RST    1'h1
`define LVPMC_DET_STOP_RST   1'h1
`define LVPMC_DET_EN_RST     1'h1
`define LVPMC_BG_EN_RST      1'h0
`define LVPMC_TWO_RST        8'h00
`define LVPMC_EV_RST         3'h0

`endif

/* File: lvpmc_ctrl.v */
// low supply detect/warning control, bandgap buffer enable and stop-mode select
// assumes analog comparator outputs and stop/recovery strobes arrive asynchronously
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`include "lvpmc_defs.vh"
module lvpmc_ctrl
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        por_i,
   input  wire [3:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   input  wire        warn_below_i,
   input  wire        detect_below_i,
   input  wire        in_stop_i,
   input  wire        deep_stop_recovered_i,
   output reg         detect_active_o,
   output reg         detect_reset_req_o,
   output reg  [1:0]  trip_code_o,
   output reg         bandgap_buffer_enable_o,
   output reg         deep_stop_select_o,
   output reg         low_supply_warning_irq_o,
   output reg         irq_o
);

////////////////////////////////////////////////////////////////////////////////
// two-flop synchronisers for all asynchronous inputs, one chain per pin
// only the second flop of a chain is read, so a metastable first
// stage never reaches the flags
wire [3:0] async_in;
wire [3:0] sync_s;
reg        rec_prev_r;
wire       warn_s;
wire       det_s;
wire       stop_s;
wire       rec_s;
wire       rec_ev;

assign async_in = {deep_stop_recovered_i, in_stop_i, detect_below_i, warn_below_i};
assign warn_s   = sync_s[0];
assign det_s    = sync_s[1];
assign stop_s   = sync_s[2];
assign rec_s    = sync_s[3];
// recovery is an event: only its rising edge sets the flag
assign rec_ev   = rec_s & ~rec_prev_r;

genvar gi;
generate
   for (gi = 0; gi < 4; gi = gi + 1)
   begin : g_sync
      reg sync1_r;
      reg sync2_r;
      always @(posedge clk_i)
      begin
         if (rst_i)
         begin
            sync1_r <= 1'h0;
            sync2_r <= 1'h0;
         end
         else
         begin
            sync1_r <= async_in[gi];
            sync2_r <= sync1_r;
         end
      end
      assign sync_s[gi] = sync2_r;
   end
endgenerate

// edge memory resets to the idle level of the pin, so no false edge
always @(posedge clk_i)
begin
   if (rst_i)
      rec_prev_r <= 1'h0;
   else
      rec_prev_r <= rec_s;
end

////////////////////////////////////////////////////////////////////////////////
// bus decode: one wait cycle on every access, so read data come from a flop
// ack_r marks the answer cycle; a write acts only there, at the edge
// where the master sees waitrequest low, so a held request lands once
reg        ack_r;
wire       req    = (avs_read_i | avs_write_i) & ~ack_r;
wire       wr_go  = avs_write_i & ack_r;
wire       lane0  = avs_byteenable_i[0];
wire [7:0] wd     = avs_writedata_i[7:0];
wire       wr_one = wr_go & lane0 & (avs_address_i == `LVPMC_OFS_ONE);
wire       wr_two = wr_go & lane0 & (avs_address_i == `LVPMC_OFS_TWO);
wire       wr_st  = wr_go & lane0 & (avs_address_i == `LVPMC_OFS_IRQ_STAT);
wire       wr_msk = wr_go & lane0 & (avs_address_i == `LVPMC_OFS_IRQ_MASK);

////////////////////////////////////////////////////////////////////////////////
// first register state
reg  warn_flag_r;
reg  warn_ie_r;
reg  det_rst_r;
reg  det_stop_r;
reg  det_en_r;
reg  bg_en_r;
reg  one_locked_r;
// second register state
reg  det_sel_r;
reg  warn_sel_r;
reg  ppd_flag_r;
reg  deep_stop_r;
reg  two_locked_r;
reg  det_sel_locked_r;
// interrupt block
reg  [2:0] ev_stat_r;
reg  [2:0] ev_mask_r;

wire warn_ack   = wr_one & wd[`LVPMC_WARN_ACK_BIT];
wire ppd_clr    = wr_two & wd[`LVPMC_PPD_CLR_BIT];
// detection is live when enabled and not suppressed by stop mode
wire det_live   = det_en_r & (~stop_s | det_stop_r);
wire det_event  = det_live & det_s;
wire [2:0] ev_set = {det_event, rec_ev, warn_s};

////////////////////////////////////////////////////////////////////////////////
// next values; a hardware event always beats a software clear in one cycle
reg        warn_flag_nxt;
reg        warn_ie_nxt;
reg        det_rst_nxt;
reg        det_stop_nxt;
reg        det_en_nxt;
reg        bg_en_nxt;
reg        one_locked_nxt;
reg        ppd_flag_nxt;
reg        deep_stop_nxt;
reg        two_locked_nxt;
reg  [2:0] ev_stat_nxt;
reg  [2:0] ev_mask_nxt;

always @*
begin
   warn_flag_nxt  = warn_flag_r;
   warn_ie_nxt    = warn_ie_r;
   det_rst_nxt    = det_rst_r;
   det_stop_nxt   = det_stop_r;
   det_en_nxt     = det_en_r;
   bg_en_nxt      = bg_en_r;
   one_locked_nxt = one_locked_r;
   ppd_flag_nxt   = ppd_flag_r;
   deep_stop_nxt  = deep_stop_r;
   two_locked_nxt = two_locked_r;
   ev_mask_nxt    = ev_mask_r;
   // acknowledge only lands once the synced condition has gone
   if (warn_s)
      warn_flag_nxt = 1'h1;
   else if (warn_ack)
      warn_flag_nxt = 1'h0;
   if (wr_one)
   begin
      warn_ie_nxt    = wd[`LVPMC_WARN_IE_BIT];
      det_stop_nxt   = wd[`LVPMC_DET_STOP_BIT];
      bg_en_nxt      = wd[`LVPMC_BG_EN_BIT];
      one_locked_nxt = 1'h1;
      // later writes leave the write-once bits alone until the next reset
      if (!one_locked_r)
      begin
         det_rst_nxt = wd[`LVPMC_DET_RST_BIT];
         det_en_nxt  = wd[`LVPMC_DET_EN_BIT];
      end
   end
   if (rec_ev)
      ppd_flag_nxt = 1'h1;
   else if (ppd_clr)
      ppd_flag_nxt = 1'h0;
   if (wr_two)
   begin
      two_locked_nxt = 1'h1;
      if (!two_locked_r)
         deep_stop_nxt = wd[`LVPMC_DEEP_STOP_BIT];
   end
   if (wr_msk)
      ev_mask_nxt = wd[2:0];
   // write-one-to-clear, but an event in the same cycle keeps its bit
   ev_stat_nxt = ev_set | (ev_stat_r & ~({3{wr_st}} & wd[2:0]));
end

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      warn_flag_r  <= 1'h0;
      warn_ie_r    <= `LVPMC_WARN_IE_RST;
      det_rst_r    <= `LVPMC_DET_RST_RST;
      det_stop_r   <= `LVPMC_DET_STOP_RST;
      det_en_r     <= `LVPMC_DET_EN_RST;
      bg_en_r      <= `LVPMC_BG_EN_RST;
      one_locked_r <= 1'h0;
      ppd_flag_r   <= 1'h0;
      deep_stop_r  <= 1'h0;
      two_locked_r <= 1'h0;
      ev_stat_r    <= `LVPMC_EV_RST;
      ev_mask_r    <= `LVPMC_EV_RST;
   end
   else
   begin
      warn_flag_r  <= warn_flag_nxt;
      warn_ie_r    <= warn_ie_nxt;
      det_rst_r    <= det_rst_nxt;
      det_stop_r   <= det_stop_nxt;
      det_en_r     <= det_en_nxt;
      bg_en_r      <= bg_en_nxt;
      one_locked_r <= one_locked_nxt;
      ppd_flag_r   <= ppd_flag_nxt;
      deep_stop_r  <= deep_stop_nxt;
      two_locked_r <= two_locked_nxt;
      ev_stat_r    <= ev_stat_nxt;
      ev_mask_r    <= ev_mask_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////
// trip selects live outside the ordinary reset
reg        det_sel_nxt;
reg        warn_sel_nxt;
reg        det_sel_locked_nxt;

always @*
begin
   det_sel_nxt        = det_sel_r;
   warn_sel_nxt       = warn_sel_r;
   det_sel_locked_nxt = det_sel_locked_r;
   // a write during reset is dropped, as for every other register
   if (wr_two && !rst_i)
   begin
      warn_sel_nxt       = wd[`LVPMC_WARN_SEL_BIT];
      det_sel_locked_nxt = 1'h1;
      if (!det_sel_locked_r)
         det_sel_nxt = wd[`LVPMC_DET_SEL_BIT];
   end
end

// trip selects only reset on power-on; other resets leave them
always @(posedge clk_i)
begin
   if (por_i)
   begin
      det_sel_r        <= 1'h0;
      warn_sel_r       <= 1'h0;
      det_sel_locked_r <= 1'h0;
   end
   else
   begin
      det_sel_r        <= det_sel_nxt;
      warn_sel_r       <= warn_sel_nxt;
      det_sel_locked_r <= det_sel_locked_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////
// read mux
reg [7:0] rd_byte;
always @*
begin
   rd_byte = 8'h00;
   case (avs_address_i)
      `LVPMC_OFS_ONE:
      begin
         // acknowledge and bit 1 read as zero
         rd_byte = {warn_flag_r, 1'b0, warn_ie_r, det_rst_r,
                    det_stop_r, det_en_r, 1'b0, bg_en_r};
      end
      `LVPMC_OFS_TWO:
      begin
         rd_byte = {2'b00, det_sel_r, warn_sel_r,
                    ppd_flag_r, 2'b00, deep_stop_r};
      end
      `LVPMC_OFS_IRQ_STAT: rd_byte = {5'h00, ev_stat_r};
      `LVPMC_OFS_IRQ_MASK: rd_byte = {5'h00, ev_mask_r};
      default:             rd_byte = 8'h00;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// every output leaves a flop, so pins lag the register state by one cycle
// the detect reset request is a level that stays while the event lasts;
// whoever turns it into a chip reset must stretch or latch it
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ack_r                    <= 1'h0;
      avs_waitrequest_o        <= 1'h1;
      avs_readdata_o           <= 32'h0000_0000;
      detect_active_o          <= 1'h0;
      detect_reset_req_o       <= 1'h0;
      trip_code_o              <= 2'h0;
      bandgap_buffer_enable_o  <= 1'h0;
      deep_stop_select_o       <= 1'h0;
      low_supply_warning_irq_o <= 1'h0;
      irq_o                    <= 1'h0;
   end
   else
   begin
      ack_r                    <= req;
      avs_waitrequest_o        <= ~req;
      avs_readdata_o           <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      detect_active_o          <= det_live;
      detect_reset_req_o       <= det_event & det_rst_r;
      trip_code_o              <= {det_sel_r, warn_sel_r};
      bandgap_buffer_enable_o  <= bg_en_r;
      deep_stop_select_o       <= deep_stop_r;
      low_supply_warning_irq_o <= warn_ie_r & warn_flag_r;
      irq_o                    <= |(ev_stat_r & ev_mask_r);
   end
end

endmodule

/* File: lvpmc_ctrl_assertions.sv */
// checker: bus answer timing and register readback against the control outputs
// assumes it is bound to lvpmc_ctrl and that the master holds a request until answered
`timescale 1ns/1ns
module lvpmc_chk
(
   input wire        clk_i,
   input wire        rst_i,
   input wire [3:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_readdata_o,
   input wire        avs_waitrequest_o,
   input wire [1:0]  trip_code_o,
   input wire        bandgap_buffer_enable_o,
   input wire        deep_stop_select_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire       req = avs_read_i || avs_write_i;
wire       ans = avs_read_i && !avs_waitrequest_o;
wire [7:0] rv  = avs_readdata_o[7:0];
sequence s_take;
   req && avs_waitrequest_o ##1 !avs_waitrequest_o;
endsequence
////////////////////////////////////////////////////////////////////////////////
a_wait_single: assert property (s_take |=> avs_waitrequest_o)
   else $error("waitrequest low for more than one cycle");
a_answer_next: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
   else $error("request not answered in the next cycle");
a_upper_zero: assert property (ans |-> avs_readdata_o[31:8] == 24'h000000)
   else $error("upper read lanes not zero");
a_two_unused: assert property (ans && avs_address_i == 4'h4 |-> rv[7:6] == 2'h0 && rv[2:1] == 2'h0)
   else $error("unused bits of second register read nonzero");
a_one_unused: assert property (ans && avs_address_i == 4'h0 |-> rv[6] == 1'b0 && rv[1] == 1'b0)
   else $error("unused bits of first register read nonzero");
a_trip_match: assert property (ans && avs_address_i == 4'h4 |-> rv[5:4] == trip_code_o)
   else $error("trip code differs from select bits");
a_bg_match: assert property (ans && avs_address_i == 4'h0 |-> rv[0] == bandgap_buffer_enable_o)
   else $error("bandgap enable differs from its bit");
a_deep_match: assert property (ans && avs_address_i == 4'h4 |-> rv[0] == deep_stop_select_o)
   else $error("deep stop select differs from its bit");
endmodule

bind lvpmc_ctrl lvpmc_chk i_lvpmc_chk (.*);

/* File: tb_lvpmc_ctrl.sv */
// testbench: register access, warning and detect events, resets and interrupts
// assumes the checker is bound from its own file; bench names equal the port names
`timescale 1ns/1ns
module tb_lvpmc_ctrl;
reg         clk_i = 0, rst_i = 1, por_i = 1, avs_read_i = 0, avs_write_i = 0;
reg  [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
reg  [31:0] avs_writedata_i = 32'h0;
reg         warn_below_i = 0, detect_below_i = 0, in_stop_i = 0, deep_stop_recovered_i = 0;
wire [31:0] avs_readdata_o;
wire        avs_waitrequest_o, detect_active_o, detect_reset_req_o, bandgap_buffer_enable_o;
wire        deep_stop_select_o, low_supply_warning_irq_o, irq_o;
wire [1:0]  trip_code_o;
reg  [7:0]  q;
integer     n_errors = 0, n_compared = 0, cyc = 0;
lvpmc_ctrl i_lvpmc_ctrl (.*);
initial forever #50 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////////////////////
task final_report;
   if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
endtask
always @(posedge clk_i)
begin
   cyc = cyc + 1;
   // whole run needs well under a thousand cycles
   if (cyc == 3000)
   begin
      n_errors = n_errors + 1;
      final_report;
   end
end
task chk(input string n, input [31:0] e, input [31:0] g);
   n_compared = n_compared + 1;
   if (g !== e)
   begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", n, e, g);
   end
endtask
// values seen right after an edge are the ones that edge sampled
task acc(input w, input [3:0] a, input [7:0] d);
   @(posedge clk_i);
   avs_read_i <= !w;
   avs_write_i <= w;
   avs_address_i <= a;
   avs_writedata_i <= {24'h0, d};
   @(posedge clk_i);
   while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
   q = avs_readdata_o[7:0];
   avs_read_i <= 0;
   avs_write_i <= 0;
endtask
task rc(input string n, input [3:0] a, input [7:0] e);
   acc(0, a, 8'h00);
   chk(n, e, q);
endtask
// settle time lets registered outputs follow the write
task wrt(input [3:0] a, input [7:0] d);
   acc(1, a, d);
   repeat (3) @(posedge clk_i);
endtask
task gap;
   repeat (6) @(posedge clk_i);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
   repeat (8) @(posedge clk_i);
   rst_i <= 0;
   por_i <= 0;
   rc("one_rst", 4'h0, 8'h1C);
   rc("two_rst", 4'h4, 8'h00);
   wrt(4'h0, 8'h21);
   wrt(4'h0, 8'h7F);
   rc("one_lock", 4'h0, 8'h29);
   chk("bg", 1, bandgap_buffer_enable_o);
   detect_below_i <= 1;
   gap;
   chk("det_off_rst", 0, detect_reset_req_o);
   chk("det_off", 0, detect_active_o);
   detect_below_i <= 0;
   warn_below_i <= 1;
   gap;
   rc("warn_set", 4'h0, 8'hA9);
   chk("wirq", 1, low_supply_warning_irq_o);
   wrt(4'h0, 8'h69);
   rc("ack_held", 4'h0, 8'hA9);
   warn_below_i <= 0;
   gap;
   rc("sticky", 4'h0, 8'hA9);
   wrt(4'h0, 8'h69);
   rc("acked", 4'h0, 8'h29);
   chk("wirq_off", 0, low_supply_warning_irq_o);
   wrt(4'hC, 8'h01);
   chk("irq_on", 1, irq_o);
   wrt(4'hC, 8'h00);
   chk("irq_mask", 0, irq_o);
   wrt(4'hC, 8'h01);
   wrt(4'h8, 8'h01);
   chk("irq_clr", 0, irq_o);
   wrt(4'h4, 8'h3F);
   rc("two_a", 4'h4, 8'h31);
   chk("trip11", 3, trip_code_o);
   chk("deep", 1, deep_stop_select_o);
   wrt(4'h4, 8'h00);
   rc("two_b", 4'h4, 8'h21);
   chk("trip10", 2, trip_code_o);
   deep_stop_recovered_i <= 1;
   gap;
   deep_stop_recovered_i <= 0;
   rc("ppd", 4'h4, 8'h29);
   wrt(4'h4, 8'h04);
   rc("ppd_clr", 4'h4, 8'h21);
   rst_i <= 1;
   repeat (2) @(posedge clk_i);
   rst_i <= 0;
   rc("two_keep", 4'h4, 8'h20);
   wrt(4'h4, 8'h01);
   rc("two_lock", 4'h4, 8'h21);
   rst_i <= 1;
   por_i <= 1;
   repeat (2) @(posedge clk_i);
   rst_i <= 0;
   por_i <= 0;
   rc("two_por", 4'h4, 8'h00);
   wrt(4'h4, 8'h10);
   chk("trip01", 1, trip_code_o);
   detect_below_i <= 1;
   in_stop_i <= 1;
   gap;
   chk("det_rst", 1, detect_reset_req_o);
   chk("stop_on", 1, detect_active_o);
   wrt(4'h0, 8'h14);
   gap;
   chk("stop_off", 0, detect_active_o);
   final_report;
end
endmodule
